/* File: hw/lpp_regs.svh */
// register offsets, field positions and reset values of the panel power and palette slice
// assumes: included by the package and the design module; definitions only
`ifndef LPP_REGS_SVH
`define LPP_REGS_SVH

// ---------------------------------------------------------------------------
// register indices (byte address is four times the index)
// ---------------------------------------------------------------------------
`define LPP_IDX_BIAS_TIMING 32'h0A00_0430
`define LPP_IDX_POWER_CTRL 32'h0A00_0432
`define LPP_IDX_IRQ_MASK 32'h0A00_0434
`define LPP_IDX_IRQ_STATUS 32'h0A00_0436
`define LPP_IDX_PTR_CTRL 32'h0A00_047E
`define LPP_IDX_TABLE_ENTRY 32'h0A00_0480

// ---------------------------------------------------------------------------
// field positions
// ---------------------------------------------------------------------------
`define LPP_BIAS_FRAME_LSB 0
`define LPP_SUPPLY_FRAME_LSB 0
`define LPP_IFACE_FRAME_LSB 5
`define LPP_POWER_ENABLE_BIT 10
`define LPP_BIAS_POL_BIT 11
`define LPP_SUPPLY_POL_BIT 14
`define LPP_TEST_MODE_BIT 15
`define LPP_OVERRUN_BIT 1
`define LPP_RETRACE_BIT 2
`define LPP_POINTER_LSB 0
`define LPP_WR_INC_BIT 8
`define LPP_RD_INC_BIT 9
`define LPP_PAGE_LSB 12
`define LPP_ENTRY_WIDTH 18
`define LPP_BLUE_LSB 0

// ---------------------------------------------------------------------------
// reset values
// ---------------------------------------------------------------------------
`define LPP_RST_REG16 16'h0000
`define LPP_FRAME_MAX 5'h1F

`endif

/* File: hw/lpp_pkg.sv */
// types shared by the panel power and palette slice
// assumes: lpp_regs.svh is on the include path
package lpp_pkg;
  `include "lpp_regs.svh"

  typedef enum logic {BUS_IDLE, BUS_DATA} lpp_bus_phase_t;

  typedef enum logic [1:0] {BPP_1, BPP_2, BPP_4, BPP_8} lpp_bpp_t;

  // ahb-lite request side as seen by the slave
  typedef struct packed {
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hready;
  } lpp_ahb_req_t;

  typedef struct packed {
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
  } lpp_ahb_resp_t;

  typedef struct packed {
    logic valid;
    logic [7:0] value;
    lpp_bpp_t bpp;
    logic mono;
  } lpp_pixel_in_t;

  typedef struct packed {
    logic valid;
    logic [17:0] colour;
    logic [5:0] grey;
  } lpp_pixel_out_t;

  typedef struct packed {
    lpp_bus_phase_t phase;
    logic [31:0] addr;
    logic wr;
    lpp_ahb_resp_t resp;
    logic [4:0] biasFrame;
    logic testMode;
    logic supplyPol;
    logic biasPol;
    logic powerEnable;
    logic [4:0] ifaceFrame;
    logic [4:0] supplyFrame;
    logic retraceUnmask;
    logic overrunUnmask;
    logic retraceSt;
    logic overrunSt;
    logic irq;
    logic [3:0] page;
    logic rdInc;
    logic wrInc;
    logic [7:0] pointer;
    logic [4:0] frameCnt;
    logic supplyOn;
    logic ifaceOn;
    logic biasOn;
    logic supplyPin;
    logic biasPin;
    lpp_pixel_out_t pix;
  } lpp_state_t;
endpackage

/* File: hw/lpp_power_palette.sv */
// panel power sequencing, interrupt masking and colour table access for an lcd controller
// assumes: one clock, synchronous reset; frame timing supplies frameTick and the two
// interrupt events on the same clock; one ahb-lite master, word transfers only
//
// Summary of operation
// - bias output turns on once frame count reaches the bias-on frame field.
// - supply output turns on once frame count reaches the supply-on frame field.
// - panel interface signals drive once frame count reaches interface-on field.
// - power enable bit: 0 sequence off, 1 sequence on.
// - supply polarity bit: 0 active low, 1 active high supply output.
// - bias polarity bit: 0 active low, 1 active high bias output.
// - test enable bit: 0 normal, 1 test mode; resets to 0.
// - retrace interrupt masked when its bit is 0, forwarded when 1.
// - overrun interrupt masked when its bit is 0, forwarded when 1.
// - in 4 bpp the page field picks the group of table entries.
// - read auto-increment set: each table read advances the pointer by one.
// - write auto-increment set: each table write advances the pointer by one.
// - mono 4 bpp takes the grey level from the blue component.
// - mono 1 and 2 bpp bypass the table and map values directly.
// - reserved writable power control bits read 0; software writes 0.
// - reserved read-only mask and pointer bits always read 0.
// - each table entry holds 18 bits, three 6-bit components.
`timescale 1ns/10ps
`include "lpp_regs.svh"

module lpp_power_palette
  import lpp_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // register bus
  input wire lpp_ahb_req_t ahbReq,
  output lpp_ahb_resp_t ahbResp,
  // frame timing and events
  input wire logic frameTick,
  input wire logic retraceEvent,
  input wire logic overrunEvent,
  // pixel lookup
  input wire lpp_pixel_in_t pixIn,
  output lpp_pixel_out_t pixOut,
  // panel side
  output logic panelSupplyOutput,
  output logic panelBiasOutput,
  output logic panelIfaceEnable,
  output logic testModeActive,
  output logic irqOut
);

  // ---------------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------------
  function automatic logic [31:0] byteAddr(input logic [31:0] idx);
    byteAddr = 32'(idx << 2);
  endfunction

  function automatic logic hits(input logic [31:0] addr, input logic [31:0] idx);
    hits = (addr == byteAddr(idx));
  endfunction

  lpp_state_t q;
  lpp_state_t d;
  logic [`LPP_ENTRY_WIDTH-1:0] colourTable [0:255];
  logic tableWrite;
  logic [7:0] tableWrIdx;
  logic [`LPP_ENTRY_WIDTH-1:0] tableWrData;
  logic [7:0] lookupIdx;
  logic tableRead;

  // ---------------------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------------------
  always_comb begin
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic accept;
    logic [`LPP_ENTRY_WIDTH-1:0] entry;
    wdata = ahbReq.hwdata;
    rdata = 32'h0000_0000;
    accept = ahbReq.hsel && ahbReq.htrans[1] && ahbReq.hready;
    entry = '0;
    d = q;
    tableWrite = 1'b0;
    tableRead = 1'b0;
    tableWrIdx = q.pointer;
    tableWrData = wdata[`LPP_ENTRY_WIDTH-1:0];
    lookupIdx = pixIn.value;

    // bus: one wait cycle so that read data come from a flop
    unique case (q.phase)
      BUS_IDLE: begin
        d.resp.hreadyout = 1'b1;
        if (accept) begin
          d.phase = BUS_DATA;
          d.addr = ahbReq.haddr;
          d.wr = ahbReq.hwrite;
          d.resp.hreadyout = 1'b0;
        end
      end
      BUS_DATA: begin
        d.phase = BUS_IDLE;
        d.resp.hreadyout = 1'b1;
        if (q.wr) begin
          if (hits(q.addr, `LPP_IDX_BIAS_TIMING)) begin
            d.biasFrame = wdata[`LPP_BIAS_FRAME_LSB +: 5];
          end
          if (hits(q.addr, `LPP_IDX_POWER_CTRL)) begin
            d.supplyFrame = wdata[`LPP_SUPPLY_FRAME_LSB +: 5];
            d.ifaceFrame = wdata[`LPP_IFACE_FRAME_LSB +: 5];
            d.powerEnable = wdata[`LPP_POWER_ENABLE_BIT];
            d.biasPol = wdata[`LPP_BIAS_POL_BIT];
            d.supplyPol = wdata[`LPP_SUPPLY_POL_BIT];
            d.testMode = wdata[`LPP_TEST_MODE_BIT];
          end
          if (hits(q.addr, `LPP_IDX_IRQ_MASK)) begin
            d.retraceUnmask = wdata[`LPP_RETRACE_BIT];
            d.overrunUnmask = wdata[`LPP_OVERRUN_BIT];
          end
          if (hits(q.addr, `LPP_IDX_IRQ_STATUS)) begin
            if (wdata[`LPP_RETRACE_BIT]) begin
              d.retraceSt = 1'b0;
            end
            if (wdata[`LPP_OVERRUN_BIT]) begin
              d.overrunSt = 1'b0;
            end
          end
          if (hits(q.addr, `LPP_IDX_PTR_CTRL)) begin
            d.pointer = wdata[`LPP_POINTER_LSB +: 8];
            d.wrInc = wdata[`LPP_WR_INC_BIT];
            d.rdInc = wdata[`LPP_RD_INC_BIT];
            d.page = wdata[`LPP_PAGE_LSB +: 4];
          end
          if (hits(q.addr, `LPP_IDX_TABLE_ENTRY)) begin
            tableWrite = 1'b1;
            d.pointer = q.pointer + 8'(q.wrInc);
          end
        end else begin
          // reserved bits are never stored, so they read back as zero
          if (hits(q.addr, `LPP_IDX_BIAS_TIMING)) begin
            rdata[`LPP_BIAS_FRAME_LSB +: 5] = q.biasFrame;
          end
          if (hits(q.addr, `LPP_IDX_POWER_CTRL)) begin
            rdata[`LPP_SUPPLY_FRAME_LSB +: 5] = q.supplyFrame;
            rdata[`LPP_IFACE_FRAME_LSB +: 5] = q.ifaceFrame;
            rdata[`LPP_POWER_ENABLE_BIT] = q.powerEnable;
            rdata[`LPP_BIAS_POL_BIT] = q.biasPol;
            rdata[`LPP_SUPPLY_POL_BIT] = q.supplyPol;
            rdata[`LPP_TEST_MODE_BIT] = q.testMode;
          end
          if (hits(q.addr, `LPP_IDX_IRQ_MASK)) begin
            rdata[`LPP_RETRACE_BIT] = q.retraceUnmask;
            rdata[`LPP_OVERRUN_BIT] = q.overrunUnmask;
          end
          if (hits(q.addr, `LPP_IDX_IRQ_STATUS)) begin
            rdata[`LPP_RETRACE_BIT] = q.retraceSt;
            rdata[`LPP_OVERRUN_BIT] = q.overrunSt;
          end
          if (hits(q.addr, `LPP_IDX_PTR_CTRL)) begin
            rdata[`LPP_POINTER_LSB +: 8] = q.pointer;
            rdata[`LPP_WR_INC_BIT] = q.wrInc;
            rdata[`LPP_RD_INC_BIT] = q.rdInc;
            rdata[`LPP_PAGE_LSB +: 4] = q.page;
          end
          if (hits(q.addr, `LPP_IDX_TABLE_ENTRY)) begin
            tableRead = 1'b1;
            entry = colourTable[q.pointer];
            rdata[`LPP_ENTRY_WIDTH-1:0] = entry;
            d.pointer = q.pointer + 8'(q.rdInc);
          end
          d.resp.hrdata = rdata;
        end
      end
    endcase
    d.resp.hresp = 1'b0;

    // interrupts: a new event wins over a clear in the same cycle
    if (retraceEvent) begin
      d.retraceSt = 1'b1;
    end
    if (overrunEvent) begin
      d.overrunSt = 1'b1;
    end
    d.irq = (d.retraceSt && d.retraceUnmask) || (d.overrunSt && d.overrunUnmask);

    // power sequence; count saturates so late steps never wrap back off
    if (!q.powerEnable) begin
      d.frameCnt = 5'h00;
    end else if (frameTick && q.frameCnt != `LPP_FRAME_MAX) begin
      d.frameCnt = q.frameCnt + 5'h01;
    end
    d.supplyOn = q.powerEnable && (q.testMode || q.frameCnt >= q.supplyFrame);
    d.ifaceOn = q.powerEnable && (q.testMode || q.frameCnt >= q.ifaceFrame);
    d.biasOn = q.powerEnable && (q.testMode || q.frameCnt >= q.biasFrame);
    d.supplyPin = d.supplyOn ~^ q.supplyPol;
    d.biasPin = d.biasOn ~^ q.biasPol;

    // pixel lookup
    unique case (pixIn.bpp)
      BPP_1: lookupIdx = {7'h00, pixIn.value[0]};
      BPP_2: lookupIdx = {6'h00, pixIn.value[1:0]};
      BPP_4: lookupIdx = {q.page, pixIn.value[3:0]};
      BPP_8: lookupIdx = pixIn.value;
    endcase
    d.pix.valid = pixIn.valid;
    d.pix.colour = colourTable[lookupIdx];
    d.pix.grey = colourTable[lookupIdx][`LPP_BLUE_LSB +: 6];
    if (pixIn.mono && pixIn.bpp == BPP_1) begin
      d.pix.grey = {6{pixIn.value[0]}};
    end else if (pixIn.mono && pixIn.bpp == BPP_2) begin
      d.pix.grey = {3{pixIn.value[1:0]}};
    end
  end

  // ---------------------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (reset) begin
      q <= '0;
      q.resp.hreadyout <= 1'b1;
      // pins idle at their inactive level, which is high for the reset polarity
      q.supplyPin <= 1'b1;
      q.biasPin <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // table contents are undefined after reset, so no reset here
  always_ff @(posedge clock) begin
    if (tableWrite) begin
      colourTable[tableWrIdx] <= tableWrData;
    end
  end

  assign ahbResp = q.resp;
  assign pixOut = q.pix;
  assign panelSupplyOutput = q.supplyPin;
  assign panelBiasOutput = q.biasPin;
  assign panelIfaceEnable = q.ifaceOn;
  assign testModeActive = q.testMode;
  assign irqOut = q.irq;

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);

  logic ptrRead;
  logic ptrWrite;
  assign ptrRead = tableRead;
  assign ptrWrite = tableWrite;

  chk_bias_on_frame: assert property (
    q.powerEnable && !q.testMode && q.frameCnt >= q.biasFrame
      |=> q.biasOn && panelBiasOutput == $past(q.biasPol))
    else $error("bias output not on at its frame");

  chk_supply_on_frame: assert property (
    q.powerEnable && q.frameCnt < q.supplyFrame && !q.testMode && !frameTick |=> !q.supplyOn)
    else $error("supply output on too early");

  chk_iface_on_frame: assert property (
    q.powerEnable && !q.testMode && q.frameCnt >= q.ifaceFrame |=> panelIfaceEnable)
    else $error("interface not driven at its frame");

  chk_power_off_all: assert property (
    !q.powerEnable |=> !panelIfaceEnable && panelSupplyOutput == !$past(q.supplyPol)
      && panelBiasOutput == !$past(q.biasPol) && q.frameCnt == 5'h00)
    else $error("outputs not inactive with power disabled");

  chk_enable_counts: assert property (
    q.powerEnable && frameTick && q.frameCnt < 5'h1F |=> q.frameCnt == $past(q.frameCnt) + 5'h01)
    else $error("frame count did not advance");

  chk_supply_polarity: assert property (
    q.supplyOn && $stable(q.supplyPol) |-> panelSupplyOutput == q.supplyPol)
    else $error("supply polarity wrong");

  chk_test_forces_on: assert property (
    q.powerEnable && q.testMode |=> q.supplyOn && q.biasOn && q.ifaceOn)
    else $error("test mode did not force outputs on");

  chk_retrace_forward: assert property (
    q.retraceSt && q.retraceUnmask |-> irqOut)
    else $error("unmasked retrace not forwarded");

  chk_irq_masked: assert property (
    !(q.retraceSt && q.retraceUnmask) && !(q.overrunSt && q.overrunUnmask) |-> !irqOut)
    else $error("masked interrupt leaked");

  chk_read_advance: assert property (
    ptrRead |=> q.pointer == $past(q.pointer) + 8'($past(q.rdInc)))
    else $error("pointer wrong after table read");

  chk_write_advance: assert property (
    ptrWrite |=> q.pointer == $past(q.pointer) + 8'($past(q.wrInc)))
    else $error("pointer wrong after table write");

  chk_reserved_zero: assert property (
    q.phase == BUS_DATA && !q.wr && hits(q.addr, `LPP_IDX_IRQ_MASK)
      |=> ahbResp.hrdata[31:3] == 29'h0000_0000 && !ahbResp.hrdata[0])
    else $error("reserved mask bits not zero");

  chk_mono_direct: assert property (
    pixIn.valid && pixIn.mono && pixIn.bpp == BPP_1 |=> pixOut.valid && pixOut.grey == {6{$past(pixIn.value[0])}})
    else $error("mono 1 bpp not mapped directly");

  chk_bus_answer: assert property (
    ahbReq.hsel && ahbReq.htrans[1] && ahbReq.hready && q.phase == BUS_IDLE
      |=> !ahbResp.hreadyout ##1 ahbResp.hreadyout)
    else $error("bus answer not in two cycles");

  chk_bias_polarity: assert property (
    q.biasOn && $stable(q.biasPol) |-> panelBiasOutput == q.biasPol)
    else $error("bias polarity wrong");

  chk_bias_off_early: assert property (
    q.powerEnable && !q.testMode && q.frameCnt < q.biasFrame |=> !q.biasOn)
    else $error("bias output on too early");

  chk_iface_off_early: assert property (
    q.powerEnable && !q.testMode && q.frameCnt < q.ifaceFrame |=> !panelIfaceEnable)
    else $error("interface driven too early");

  chk_retrace_sticky: assert property (
    retraceEvent |=> q.retraceSt)
    else $error("retrace event not latched");

  chk_overrun_sticky: assert property (
    overrunEvent |=> q.overrunSt)
    else $error("overrun event not latched");

  chk_page_lookup: assert property (
    pixIn.valid && pixIn.bpp == BPP_4 |=> pixOut.colour == $past(colourTable[{q.page, pixIn.value[3:0]}]))
    else $error("4 bpp lookup ignores the page");

  chk_mono_grey: assert property (
    pixIn.valid && pixIn.mono && pixIn.bpp == BPP_4
      |=> pixOut.grey == $past(colourTable[{q.page, pixIn.value[3:0]}][`LPP_BLUE_LSB +: 6]))
    else $error("mono grey not from blue component");

  chk_mono_two_bpp: assert property (
    pixIn.valid && pixIn.mono && pixIn.bpp == BPP_2 |=> pixOut.grey == {3{$past(pixIn.value[1:0])}})
    else $error("mono 2 bpp not mapped directly");

  chk_entry_stored: assert property (
    ptrWrite |=> colourTable[$past(q.pointer)] == $past(ahbReq.hwdata[`LPP_ENTRY_WIDTH-1:0]))
    else $error("table entry not stored whole");

  chk_entry_read: assert property (
    ptrRead |=> ahbResp.hrdata == {14'h0, $past(colourTable[q.pointer])})
    else $error("table entry read wrong");

  chk_power_reserved: assert property (
    q.phase == BUS_DATA && !q.wr && hits(q.addr, `LPP_IDX_POWER_CTRL)
      |=> ahbResp.hrdata[31:16] == 16'h0000 && ahbResp.hrdata[13:12] == 2'h0)
    else $error("reserved power control bits not zero");

  chk_timing_reserved: assert property (
    q.phase == BUS_DATA && !q.wr && hits(q.addr, `LPP_IDX_BIAS_TIMING)
      |=> ahbResp.hrdata[31:5] == 27'h0)
    else $error("reserved bias timing bits not zero");

  chk_pointer_reserved: assert property (
    q.phase == BUS_DATA && !q.wr && hits(q.addr, `LPP_IDX_PTR_CTRL)
      |=> ahbResp.hrdata[31:16] == 16'h0000 && ahbResp.hrdata[11:10] == 2'h0)
    else $error("reserved pointer bits not zero");

  cov_sequence_done: cover property (q.supplyOn && q.ifaceOn && q.biasOn && !q.testMode);
  cov_table_read_inc: cover property (ptrRead && q.rdInc);
  cov_irq_raised: cover property (!irqOut ##1 irqOut);
  cov_page_lookup: cover property (pixIn.valid && pixIn.bpp == BPP_4 && q.page != 4'h0);
  cov_power_dropped: cover property (q.powerEnable ##1 !q.powerEnable);

endmodule

/* File: tb/lpp_panel_model.sv */
// lcd panel with its supply and bias switches, as seen from the controller pins
// assumes: pins are levels on the controller clock; switch polarity straps are set by the bench
`timescale 1ns/10ps

module lpp_panel_model (
  // switch straps
  input wire logic supplyHigh,
  input wire logic biasHigh,
  // controller pins
  input wire logic supplyPin,
  input wire logic biasPin,
  input wire logic ifaceEnable,
  // panel state
  output logic supplyPowered,
  output logic biasPowered,
  output logic displaying
);
  // a switch closes only on its strapped level; an unknown pin leaves it open
  assign supplyPowered = (supplyPin === supplyHigh);
  assign biasPowered = (biasPin === biasHigh);
  // image shows once logic signals and supply are up; table writes must wait for this to drop
  assign displaying = (ifaceEnable === 1'b1) && supplyPowered;
endmodule

/* File: tb/tb_top.sv */
// self-checking bench of the panel power and palette slice
// assumes: lpp_pkg compiled first; one ahb-lite master, word transfers, slave always OKAY
`timescale 1ns/10ps

module tb_top;
  import lpp_pkg::*;
  localparam logic [31:0] A_BIAS = 32'h2800_10C0;
  localparam logic [31:0] A_PWR = 32'h2800_10C8;
  localparam logic [31:0] A_MASK = 32'h2800_10D0;
  localparam logic [31:0] A_STAT = 32'h2800_10D8;
  localparam logic [31:0] A_PTR = 32'h2800_11F8;
  localparam logic [31:0] A_TAB = 32'h2800_1200;
  localparam logic [31:0] WA [5] = '{A_BIAS, A_PWR, A_MASK, A_PTR, 32'h2800_1100};
  localparam logic [31:0] WD [5] = '{32'hFFFF_801F, 32'hFFFF_C3E0, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF};
  localparam logic [31:0] RB [5] = '{32'h0000_001F, 32'h0000_C3E0, 32'h0000_0006, 32'h0000_F3FF, 32'h0};
  logic clock = 1'b0;
  logic reset = 1'b1;
  lpp_ahb_req_t busReq = '0;
  lpp_ahb_req_t ahbReq;
  lpp_ahb_resp_t ahbResp;
  logic frameTick = 1'b0;
  logic retraceEvent = 1'b0;
  logic overrunEvent = 1'b0;
  lpp_pixel_in_t pixIn = '0;
  lpp_pixel_out_t pixOut;
  logic panelSupplyOutput, panelBiasOutput, panelIfaceEnable, testModeActive, irqOut;
  logic supplyHigh = 1'b0;
  logic biasHigh = 1'b0;
  logic supplyPowered, biasPowered, displaying;
  int errCount = 0;
  int comparisons = 0;
  int cycles = 0;

  always #4 clock = ~clock;

  // single slave: its hreadyout is the bus hready
  always_comb begin
    ahbReq = busReq;
    ahbReq.hready = ahbResp.hreadyout;
  end

  lpp_power_palette lpp_power_palette_i (
    .clock(clock), .reset(reset), .ahbReq(ahbReq), .ahbResp(ahbResp), .frameTick(frameTick),
    .retraceEvent(retraceEvent), .overrunEvent(overrunEvent), .pixIn(pixIn), .pixOut(pixOut),
    .panelSupplyOutput(panelSupplyOutput), .panelBiasOutput(panelBiasOutput),
    .panelIfaceEnable(panelIfaceEnable), .testModeActive(testModeActive), .irqOut(irqOut)
  );

  lpp_panel_model lpp_panel_model_i (
    .supplyHigh(supplyHigh), .biasHigh(biasHigh), .supplyPin(panelSupplyOutput),
    .biasPin(panelBiasOutput), .ifaceEnable(panelIfaceEnable), .supplyPowered(supplyPowered),
    .biasPowered(biasPowered), .displaying(displaying)
  );

  // ---------------------------------------------------------------------------
  // bus and check tasks
  // ---------------------------------------------------------------------------
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, errCount);
    if (errCount == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errCount++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clock);
  endtask

  // called just after a rising edge; returns at the edge that completes the data phase
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
    busReq.hsel <= 1'b1;
    busReq.haddr <= a;
    busReq.htrans <= 2'h2;
    busReq.hwrite <= w;
    busReq.hsize <= 3'h2;
    @(posedge clock);
    while (ahbResp.hreadyout !== 1'b1) @(posedge clock);
    busReq.htrans <= 2'h0;
    busReq.hwdata <= d;
    @(posedge clock);
    while (ahbResp.hreadyout !== 1'b1) @(posedge clock);
    r = ahbResp.hrdata;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, a, d, r);
  endtask

  task automatic rdchk(input string what, input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] r;
    xfer(1'b0, a, 32'h0, r);
    check(what, r, exp);
    check("bus response", ahbResp.hresp, 1'b0);
  endtask

  task automatic pulse(input int which);
    if (which == 0) frameTick <= 1'b1;
    else if (which == 1) overrunEvent <= 1'b1;
    else retraceEvent <= 1'b1;
    @(posedge clock);
    frameTick <= 1'b0;
    overrunEvent <= 1'b0;
    retraceEvent <= 1'b0;
    idle(3);
  endtask

  task automatic pix(input logic [7:0] v, input lpp_bpp_t b, input logic m);
    pixIn <= '{valid: 1'b1, value: v, bpp: b, mono: m};
    idle(2);
  endtask

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      errCount++;
      complete_run();
    end
  end

  // ---------------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------------
  initial begin
    idle(3);
    reset <= 1'b0;
    idle(3);
    check("supply at reset", supplyPowered, 1'b0);
    check("bias at reset", biasPowered, 1'b0);
    check("iface at reset", panelIfaceEnable, 1'b0);
    check("test at reset", testModeActive, 1'b0);
    check("irq at reset", irqOut, 1'b0);
    for (int i = 0; i < 5; i++) begin
      rdchk("reset value", WA[i], 32'h0);
      wr(WA[i], WD[i]);
      rdchk("reserved bits", WA[i], RB[i]);
      wr(WA[i], 32'h0);
    end
    // staged power-up: supply at frame 1, interface at 2, bias at 3
    supplyHigh <= 1'b1;
    wr(A_BIAS, 32'h0000_0003);
    wr(A_PWR, 32'h0000_4441);
    idle(3);
    for (int k = 0; k < 5; k++) begin
      if (k > 0) pulse(0);
      check("supply step", supplyPowered, k >= 1);
      check("iface step", panelIfaceEnable, k >= 2);
      check("bias step", biasPowered, k >= 3);
    end
    wr(A_PWR, 32'h0000_4041);
    idle(3);
    check("supply off", supplyPowered, 1'b0);
    check("iface off", panelIfaceEnable, 1'b0);
    check("bias off", biasPowered, 1'b0);
    wr(A_PWR, 32'h0000_4441);
    idle(3);
    check("count restarts", supplyPowered, 1'b0);
    supplyHigh <= 1'b0;
    biasHigh <= 1'b1;
    wr(A_PWR, 32'h0000_8C00);
    idle(3);
    check("test flag", testModeActive, 1'b1);
    check("supply low active", supplyPowered, 1'b1);
    check("bias high active", biasPowered, 1'b1);
    check("iface in test", panelIfaceEnable, 1'b1);
    check("bias pin level", panelBiasOutput, 1'b1);
    // interrupts: event while masked, then unmask, then clear
    for (int b = 1; b < 3; b++) begin
      pulse(b);
      check("masked irq", irqOut, 1'b0);
      rdchk("status set", A_STAT, 32'h1 << b);
      wr(A_MASK, 32'h1 << b);
      idle(2);
      check("unmasked irq", irqOut, 1'b1);
      wr(A_STAT, 32'h1 << b);
      idle(2);
      check("cleared irq", irqOut, 1'b0);
      rdchk("status clear", A_STAT, 32'h0);
      wr(A_MASK, 32'h0);
    end
    // colour table is touched only with the panel dark
    wr(A_PWR, 32'h0);
    idle(3);
    check("panel dark", displaying, 1'b0);
    wr(A_PTR, 32'h0000_0110);
    for (int k = 0; k < 2; k++) wr(A_TAB, 32'hFFFF_0A50 + k);
    rdchk("pointer after writes", A_PTR, 32'h0000_0112);
    wr(A_PTR, 32'h0000_0210);
    for (int k = 0; k < 2; k++) rdchk("entry", A_TAB, 32'h0003_0A50 + k);
    rdchk("pointer after reads", A_PTR, 32'h0000_0212);
    wr(A_PTR, 32'h0000_0011);
    wr(A_TAB, 32'h0002_1234);
    for (int k = 0; k < 2; k++) rdchk("entry no step", A_TAB, 32'h0002_1234);
    rdchk("pointer held", A_PTR, 32'h0000_0011);
    wr(A_PTR, 32'h0000_1000);
    pix(8'hF1, BPP_4, 1'b0);
    check("page lookup", pixOut.colour, 32'h0002_1234);
    pix(8'h00, BPP_4, 1'b0);
    check("page lookup low", pixOut.colour, 32'h0003_0A50);
    pix(8'h01, BPP_4, 1'b1);
    check("mono grey", pixOut.grey, 32'h0000_0034);
    pix(8'h01, BPP_1, 1'b1);
    check("mono 1bpp", pixOut.grey, 32'h0000_003F);
    pix(8'h02, BPP_2, 1'b1);
    check("mono 2bpp", pixOut.grey, 32'h0000_002A);
    check("pixel valid", pixOut.valid, 1'b1);
    wr(A_PTR, 32'h0);
    pix(8'h11, BPP_8, 1'b0);
    check("8 bpp lookup", pixOut.colour, 32'h0002_1234);
    complete_run();
  end
endmodule
